// >>> bench/gpio_ports_b_c_d_sva.sv
// assertion checker bound to the general-purpose port block
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_chk
    import gpio_ports_pkg::*;
(
    // clock, reset and bus
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and peripheral control
    input wire logic [ANALOG_WIDTH-1:0] analog_pin_oe,
    input wire logic [BIDIR_WIDTH-1:0] bidir_pin_oe,
    input wire logic [BIDIR_WIDTH-1:0] bidir_pullup_on,
    input wire logic [SHARED_WIDTH-1:0] shared_pin_oe,
    input wire logic [SHARED_WIDTH-1:0] shared_pullup_on,
    input wire logic can_pin_enable,
    input wire logic serial_periph_enable,
    input wire logic serial_periph_master_select,
    input wire logic [7:0] timer_edge_level_select
);
    logic take;
    // a request counts once, on the edge where ack is still low
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_ACK_NEXT: assert property (take |=> wb_ack_o)
        else $error("no ack after a taken request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_UNMAPPED_ZERO: assert property (take && !wb_we_i
        && (wb_adr_i == 8'h00 || wb_adr_i > PERIPH_CONTROL_ADDR) |=> wb_dat_o == UNMAPPED_READ)
        else $error("unmapped read not zero");
    AST_DIR_RESET: assert property ($rose(resetn) |-> analog_pin_oe == 8'h00
        && bidir_pin_oe == 7'h00 && shared_pin_oe == 8'h00) else $error("pin driven after reset");
    AST_PULLUP_INPUT_ONLY: assert property ((bidir_pullup_on & bidir_pin_oe) == 7'h00
        && (shared_pullup_on & shared_pin_oe) == 8'h00) else $error("pullup on driven pin");
    AST_CAN_CLAIM: assert property (can_pin_enable [*3] |-> bidir_pin_oe[0]
        && !bidir_pin_oe[1]) else $error("can pins not claimed");
    AST_SS_INPUT: assert property (
        (serial_periph_enable && !serial_periph_master_select) [*3]
        |-> !shared_pin_oe[0] && shared_pin_oe[3:1] == 3'b001) else $error("slave pins wrong");
    AST_MASTER_DRIVE: assert property (
        (serial_periph_enable && serial_periph_master_select) [*3]
        |-> shared_pin_oe[3:1] == 3'b110) else $error("master pins wrong");
    AST_TIMER_PULLUP_OFF: assert property ((timer_edge_level_select[1:0] != 2'b00) [*3]
        |-> !shared_pullup_on[TIMER_PIN_LSB]) else $error("pullup on timer pin");
    AST_CTRL_WRITE: assert property (take && wb_we_i && wb_sel_i[0]
        && wb_adr_i == PERIPH_CONTROL_ADDR |=> ##[0:1] {serial_periph_master_select,
        serial_periph_enable, can_pin_enable} == $past(wb_dat_i[2:0]))
        else $error("ctrl write lost");
    // main scenarios reached
    cover property (take && wb_we_i);
    cover property (can_pin_enable [*3]);
    cover property (serial_periph_enable && serial_periph_master_select);
endmodule : gpio_ports_chk
bind gpio_ports_b_c_d gpio_ports_chk gpio_ports_chk_i (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .analog_pin_oe(analog_pin_oe), .bidir_pin_oe(bidir_pin_oe),
    .bidir_pullup_on(bidir_pullup_on), .shared_pin_oe(shared_pin_oe),
    .shared_pullup_on(shared_pullup_on), .can_pin_enable(can_pin_enable),
    .serial_periph_enable(serial_periph_enable),
    .serial_periph_master_select(serial_periph_master_select),
    .timer_edge_level_select(timer_edge_level_select)
);
`default_nettype wire

// >>> bench/gpio_ports_b_c_d_tb.sv
// self-checking bench for the three general-purpose ports
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_b_c_d_tb;
    import gpio_ports_pkg::*;
    localparam logic [7:0] M [3] = '{8'hff, 8'h7f, 8'hff};
    localparam logic [7:0] DA [3] = '{ANALOG_PORT_DATA_ADDR, BIDIR_PORT_DATA_ADDR,
        SHARED_PORT_DATA_ADDR};
    localparam logic [7:0] RA [3] = '{ANALOG_PORT_DIRECTION_ADDR, BIDIR_PORT_DIRECTION_ADDR,
        SHARED_PORT_DIRECTION_ADDR};
    // analog port has no pullup register: its slot is an unmapped address
    localparam logic [7:0] PA [3] = '{8'h28, BIDIR_PORT_PULLUP_ENABLE_ADDR,
        SHARED_PORT_PULLUP_ENABLE_ADDR};
    logic clk = 1'b0, resetn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0, t_oe = 4'h0;
    logic [31:0] wb_dat = 32'h0, rdat, wb_rd;
    logic [7:0] ext [3] = '{default: 8'h00}, drv [3] = '{default: 8'hff};
    logic [7:0] lat [3], dir [3], pu [3], lvl [3], pout [3], poe [3], pon [3], tsel, ex;
    logic [15:0] ctrl;
    logic can_en, sp_en, sp_ms;
    int fail_count = 0, num_checks = 0, cycles = 0;
    gpio_ports_b_c_d gpio_ports_b_c_d_i (
        .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(rdat),
        .wb_ack_o(wb_ack),
        .analog_pin_in(lvl[0]), .analog_pin_out(pout[0]), .analog_pin_oe(poe[0]),
        .bidir_pin_in(lvl[1][6:0]), .bidir_pin_out(pout[1][6:0]), .bidir_pin_oe(poe[1][6:0]),
        .bidir_pullup_on(pon[1][6:0]), .shared_pin_in(lvl[2]), .shared_pin_out(pout[2]),
        .shared_pin_oe(poe[2]), .shared_pullup_on(pon[2]), .can_transmit(ext[1][0]),
        .timer_channel_out(ext[2][7:4]), .timer_channel_oe(t_oe),
        .serial_periph_clock_out(ext[2][3]), .serial_periph_master_out(ext[2][2]),
        .serial_periph_master_in_out(ext[2][1]), .can_pin_enable(can_en),
        .serial_periph_enable(sp_en), .serial_periph_master_select(sp_ms),
        .timer_edge_level_select(tsel));
    pad_model #(.W(8)) pad_model_a_i (.clk(clk), .ext(ext[0]), .drv(drv[0]), .out(pout[0]),
        .oe(poe[0]), .pu(8'h00), .lvl(lvl[0]));
    pad_model #(.W(7)) pad_model_b_i (.clk(clk), .ext(ext[1][6:0]), .drv(drv[1][6:0]),
        .out(pout[1][6:0]), .oe(poe[1][6:0]), .pu(pon[1][6:0]), .lvl(lvl[1][6:0]));
    pad_model #(.W(8)) pad_model_s_i (.clk(clk), .ext(ext[2]), .drv(drv[2]), .out(pout[2]),
        .oe(poe[2]), .pu(pon[2]), .lvl(lvl[2]));
    always #5 clk = ~clk;
    // pins taken from port logic by the peripherals
    function automatic logic [7:0] claim(input int p);
        logic [7:0] c;
        c = 8'h00;
        if (p == 1 && ctrl[0]) c = 8'h03;
        if (p == 2 && ctrl[1]) c = {4'h0, 3'b111, !ctrl[2]};
        for (int i = 0; i < 4; i++)
            if (p == 2 && ctrl[8 + 2 * i +: 2] != 2'b00) c[4 + i] = 1'b1;
        return c;
    endfunction : claim
    function automatic logic [7:0] oe_exp(input int p);
        logic [7:0] pd;
        pd = (p == 1) ? 8'h01 : {t_oe, ctrl[2], ctrl[2], !ctrl[2], 1'b0};
        return ((dir[p] & ~claim(p)) | (pd & claim(p))) & M[p];
    endfunction : oe_exp
    function automatic logic [7:0] pue(input int p);
        return pu[p] & ~dir[p] & ~claim(p) & M[p];
    endfunction : pue
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one classic cycle; waits for ack (only the hang guard ends it), then idles a cycle
    task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, a, s, d};
        @(posedge clk);
        while (wb_ack !== 1'b1) begin
            @(posedge clk);
        end
        wb_rd = rdat;
        {wb_cyc, wb_stb} <= 2'b00;
        @(posedge clk);
    endtask : acc
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // hang guard, well above the roughly 1400 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        void'($urandom(61773));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int p = 0; p < 3; p++) begin
            acc(0, RA[p], 4'hf, 0);
            chk("dir reset", 0, wb_rd);
            acc(0, PA[p], 4'hf, 0);
            chk("pullup reset", 0, wb_rd);
        end
        for (int it = 0; it < 24; it++) begin
            ctrl = {8'($urandom), 5'h00, 3'(it)};
            t_oe <= 4'($urandom);
            acc(1, PERIPH_CONTROL_ADDR, 4'hf, 32'(ctrl));
            for (int p = 0; p < 3; p++) begin
                lat[p] = 8'($urandom);
                dir[p] = 8'($urandom) & M[p];
                pu[p] = (p == 0) ? 8'h00 : 8'($urandom) & M[p];
                ext[p] <= 8'($urandom);
                drv[p] <= ~pue(p);
                acc(1, DA[p], 4'h1, 32'(lat[p]));
                acc(1, RA[p], 4'h1, 32'(dir[p]));
                acc(1, PA[p], 4'h1, 32'(pu[p]));
            end
            repeat (6) @(posedge clk);
            chk("ctrl pins", 32'(ctrl), 32'({tsel, 5'h00, sp_ms, sp_en, can_en}));
            acc(0, PERIPH_CONTROL_ADDR, 4'hf, 0);
            chk("ctrl reg", 32'(ctrl), wb_rd);
            for (int p = 0; p < 3; p++) begin
                chk("oe", 32'(oe_exp(p)), 32'(poe[p] & M[p]));
                ex = dir[p] & ~claim(p);
                chk("out", 32'(lat[p] & ex), 32'(pout[p] & ex));
                if (p > 0) chk("pullup", 32'(pue(p)), 32'(pon[p] & M[p]));
                acc(0, DA[p], 4'hf, 0);
                ex = ((lat[p] & dir[p]) | ((pue(p) | ext[p]) & ~dir[p])) & M[p];
                chk("data", 32'(ex), wb_rd);
                acc(0, RA[p], 4'hf, 0);
                chk("dir", 32'(dir[p]), wb_rd);
            end
        end
        acc(1, SHARED_PORT_DATA_ADDR, 4'h0, 32'h000000a5);
        acc(0, 8'h00, 4'hf, 0);
        chk("unmapped", 0, wb_rd);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        acc(0, PERIPH_CONTROL_ADDR, 4'hf, 0);
        chk("ctrl reset", 0, wb_rd);
        for (int p = 0; p < 3; p++) begin
            acc(1, RA[p], 4'h1, 32'hff);
            acc(0, DA[p], 4'hf, 0);
            chk("latch kept", 32'(lat[p] & M[p]), wb_rd);
        end
        results();
    end
endmodule : gpio_ports_b_c_d_tb
`default_nettype wire

// >>> bench/pad_model.sv
// board-side model of one port's pads: drivers, pullups and floating level
`timescale 1ns/1ps
`default_nettype none
module pad_model #(
    parameter int W = 8
) (
    // board side
    input wire logic clk,
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] drv,
    // device side
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    output logic [W-1:0] lvl
);
    logic [W-1:0] flt = '0;
    // a pad nobody holds must not keep a stable value
    always @(posedge clk) flt <= ~flt;
    // device drive wins, then the board, then the pullup; else it floats
    assign lvl = (oe & out) | (~oe & drv & ext) | (~oe & ~drv & pu)
        | (~oe & ~drv & ~pu & flt);
endmodule : pad_model
`default_nettype wire

// >>> hdl/gpio_ports_b_c_d.sv
// general-purpose port logic for analog, bidirectional and shared ports
// Overview of operation
// - direction one drives pin, zero inputs
// - reset clears all direction registers
// - reset leaves data latches untouched
// - analog read: latch if output, else pin
// - bidirectional read: latch if output, else pin
// - data writes with byte lane zero update the latch
// - analog inputs float, outputs drive latch
// - bidirectional port has seven pins
// - pullup only while direction is input
// - pullup plus input gives pulled-high input
// - can enable claims bidirectional pins one, zero
// - shared port: serial, timers, pullups
// - nonzero timer select claims channel pin
// - serial disabled returns clock, data pins
// - slave select free if disabled or master
// - serial pins ignore direction, not readback
// - enabled serial slave keeps slave select input
// - shared read: latch if output, else pin
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_b_c_d
    import gpio_ports_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog-shared port pins
    input wire logic [ANALOG_WIDTH-1:0] analog_pin_in,
    output logic [ANALOG_WIDTH-1:0] analog_pin_out,
    output logic [ANALOG_WIDTH-1:0] analog_pin_oe,
    // bidirectional port pins
    input wire logic [BIDIR_WIDTH-1:0] bidir_pin_in,
    output logic [BIDIR_WIDTH-1:0] bidir_pin_out,
    output logic [BIDIR_WIDTH-1:0] bidir_pin_oe,
    output logic [BIDIR_WIDTH-1:0] bidir_pullup_on,
    // shared port pins
    input wire logic [SHARED_WIDTH-1:0] shared_pin_in,
    output logic [SHARED_WIDTH-1:0] shared_pin_out,
    output logic [SHARED_WIDTH-1:0] shared_pin_oe,
    output logic [SHARED_WIDTH-1:0] shared_pullup_on,
    // peripheral side of the pins
    input wire logic can_transmit,
    input wire logic [3:0] timer_channel_out,
    input wire logic [3:0] timer_channel_oe,
    input wire logic serial_periph_clock_out,
    input wire logic serial_periph_master_out,
    input wire logic serial_periph_master_in_out,
    output logic can_pin_enable,
    output logic serial_periph_enable,
    output logic serial_periph_master_select,
    output logic [7:0] timer_edge_level_select
);

    // registers
    logic [ANALOG_WIDTH-1:0] analog_port_data, next_analog_port_data;
    logic [BIDIR_WIDTH-1:0] bidir_port_data, next_bidir_port_data;
    logic [SHARED_WIDTH-1:0] shared_port_data, next_shared_port_data;
    logic [ANALOG_WIDTH-1:0] analog_port_direction, next_analog_port_direction;
    logic [BIDIR_WIDTH-1:0] bidir_port_direction, next_bidir_port_direction;
    logic [SHARED_WIDTH-1:0] shared_port_direction, next_shared_port_direction;
    logic [BIDIR_WIDTH-1:0] bidir_port_pullup_enable, next_bidir_port_pullup_enable;
    logic [SHARED_WIDTH-1:0] shared_port_pullup_enable, next_shared_port_pullup_enable;
    logic [15:0] periph_control, next_periph_control;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;

    // pin synchronisers, three stages each
    logic [ANALOG_WIDTH-1:0] analog_s1, analog_s2, analog_s3, analog_level;
    logic [BIDIR_WIDTH-1:0] bidir_s1, bidir_s2, bidir_s3, bidir_level;
    logic [SHARED_WIDTH-1:0] shared_s1, shared_s2, shared_s3, shared_level;
    logic [ANALOG_WIDTH-1:0] next_analog_level;
    logic [BIDIR_WIDTH-1:0] next_bidir_level;
    logic [SHARED_WIDTH-1:0] next_shared_level;

    // pin drive
    logic [ANALOG_WIDTH-1:0] next_analog_pin_out, next_analog_pin_oe;
    logic [BIDIR_WIDTH-1:0] next_bidir_pin_out, next_bidir_pin_oe, next_bidir_pullup_on;
    logic [SHARED_WIDTH-1:0] next_shared_pin_out, next_shared_pin_oe;
    logic [SHARED_WIDTH-1:0] next_shared_pullup_on;
    logic [SHARED_WIDTH-1:0] shared_claimed;
    // decoded bus request
    logic [7:0] wr_byte;
    logic bus_write, bus_read;

    // request taken only while ack is low, so each access answers once
    assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign bus_read = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign wr_byte = wb_dat_i[7:0];

    // two-of-three agreement: while stages two and three disagree the old level holds
    // a pin change reaches a port read about four cycles later
    always_comb begin
        next_analog_level = (analog_s2 & analog_s3) | (analog_level & (analog_s2 | analog_s3));
        next_bidir_level = (bidir_s2 & bidir_s3) | (bidir_level & (bidir_s2 | bidir_s3));
        next_shared_level = (shared_s2 & shared_s3) | (shared_level & (shared_s2 | shared_s3));
    end

    // pins are asynchronous, a level counts once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            analog_s1 <= '0;
            analog_s2 <= '0;
            analog_s3 <= '0;
            analog_level <= '0;

            bidir_s1 <= '0;
            bidir_s2 <= '0;
            bidir_s3 <= '0;
            bidir_level <= '0;

            shared_s1 <= '0;
            shared_s2 <= '0;
            shared_s3 <= '0;
            shared_level <= '0;
        end else begin
            analog_s1 <= analog_pin_in;
            analog_s2 <= analog_s1;
            analog_s3 <= analog_s2;
            analog_level <= next_analog_level;

            bidir_s1 <= bidir_pin_in;
            bidir_s2 <= bidir_s1;
            bidir_s3 <= bidir_s2;
            bidir_level <= next_bidir_level;

            shared_s1 <= shared_pin_in;
            shared_s2 <= shared_s1;
            shared_s3 <= shared_s2;
            shared_level <= next_shared_level;
        end
    end

    // register writes on the bus clock
    always_comb begin
        next_analog_port_data = analog_port_data;
        next_bidir_port_data = bidir_port_data;
        next_shared_port_data = shared_port_data;
        next_analog_port_direction = analog_port_direction;
        next_bidir_port_direction = bidir_port_direction;
        next_shared_port_direction = shared_port_direction;
        next_bidir_port_pullup_enable = bidir_port_pullup_enable;
        next_shared_port_pullup_enable = shared_port_pullup_enable;
        next_periph_control = periph_control;

        if (bus_write) begin
            case (wb_adr_i)
                // latch written whatever the direction
                ANALOG_PORT_DATA_ADDR: next_analog_port_data = wr_byte;
                BIDIR_PORT_DATA_ADDR: next_bidir_port_data = wr_byte[BIDIR_WIDTH-1:0];
                SHARED_PORT_DATA_ADDR: next_shared_port_data = wr_byte;
                ANALOG_PORT_DIRECTION_ADDR: next_analog_port_direction = wr_byte;
                BIDIR_PORT_DIRECTION_ADDR: next_bidir_port_direction = wr_byte[BIDIR_WIDTH-1:0];
                SHARED_PORT_DIRECTION_ADDR: next_shared_port_direction = wr_byte;
                BIDIR_PORT_PULLUP_ENABLE_ADDR:
                    next_bidir_port_pullup_enable = wr_byte[BIDIR_WIDTH-1:0];
                SHARED_PORT_PULLUP_ENABLE_ADDR: next_shared_port_pullup_enable = wr_byte;
                // timer selects sit in the upper byte, written only with its lane
                PERIPH_CONTROL_ADDR: begin
                    next_periph_control[7:0] = wr_byte;
                    if (wb_sel_i[1]) begin
                        next_periph_control[15:8] = wb_dat_i[15:8];
                    end
                end
                default: ; // unmapped writes are dropped
            endcase
        end
    end

    // data latches have no reset so their content survives a reset
    always_ff @(posedge clk) begin
        analog_port_data <= next_analog_port_data;
        bidir_port_data <= next_bidir_port_data;
        shared_port_data <= next_shared_port_data;
    end

    // control registers clear on reset, every pin starts as input
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            analog_port_direction <= DIRECTION_RESET;
            bidir_port_direction <= DIRECTION_RESET[BIDIR_WIDTH-1:0];
            shared_port_direction <= DIRECTION_RESET;
            bidir_port_pullup_enable <= PULLUP_RESET[BIDIR_WIDTH-1:0];
            shared_port_pullup_enable <= PULLUP_RESET;
            periph_control <= PERIPH_CONTROL_RESET;
        end else begin
            analog_port_direction <= next_analog_port_direction;
            bidir_port_direction <= next_bidir_port_direction;
            shared_port_direction <= next_shared_port_direction;
            bidir_port_pullup_enable <= next_bidir_port_pullup_enable;
            shared_port_pullup_enable <= next_shared_port_pullup_enable;
            periph_control <= next_periph_control;
        end
    end

    // read mux and single-cycle ack
    always_comb begin
        next_wb_ack_o = (wb_cyc_i && wb_stb_i && !wb_ack_o);
        next_wb_dat_o = UNMAPPED_READ;

        if (bus_read) begin
            case (wb_adr_i)
                ANALOG_PORT_DATA_ADDR:
                    next_wb_dat_o[7:0] = (analog_port_direction & analog_port_data)
                        | (~analog_port_direction & analog_level);
                BIDIR_PORT_DATA_ADDR:
                    next_wb_dat_o[BIDIR_WIDTH-1:0] = (bidir_port_direction & bidir_port_data)
                        | (~bidir_port_direction & bidir_level);
                // direction still selects latch or pin on claimed pins
                SHARED_PORT_DATA_ADDR:
                    next_wb_dat_o[7:0] = (shared_port_direction & shared_port_data)
                        | (~shared_port_direction & shared_level);
                ANALOG_PORT_DIRECTION_ADDR: next_wb_dat_o[7:0] = analog_port_direction;
                // upper bit of seven-bit registers reads zero
                BIDIR_PORT_DIRECTION_ADDR:
                    next_wb_dat_o[BIDIR_WIDTH-1:0] = bidir_port_direction;
                SHARED_PORT_DIRECTION_ADDR: next_wb_dat_o[7:0] = shared_port_direction;
                BIDIR_PORT_PULLUP_ENABLE_ADDR:
                    next_wb_dat_o[BIDIR_WIDTH-1:0] = bidir_port_pullup_enable;
                SHARED_PORT_PULLUP_ENABLE_ADDR: next_wb_dat_o[7:0] = shared_port_pullup_enable;
                PERIPH_CONTROL_ADDR: next_wb_dat_o[15:0] = periph_control;
                default: next_wb_dat_o = UNMAPPED_READ;
            endcase
        end
    end

    // which shared pins a peripheral owns
    always_comb begin
        shared_claimed = '0;

        // slave select only owned by an enabled slave
        shared_claimed[SLAVE_SELECT_PIN] = periph_control[SERIAL_PERIPH_ENABLE_BIT]
            && !periph_control[SERIAL_PERIPH_MASTER_SELECT_BIT];
        shared_claimed[MASTER_IN_PIN] = periph_control[SERIAL_PERIPH_ENABLE_BIT];
        shared_claimed[MASTER_OUT_PIN] = periph_control[SERIAL_PERIPH_ENABLE_BIT];
        shared_claimed[SERIAL_PERIPH_CLOCK_PIN] = periph_control[SERIAL_PERIPH_ENABLE_BIT];
        for (int i = 0; i < 4; i++) begin
            // cleared select field leaves pin to the port
            shared_claimed[TIMER_PIN_LSB+i] =
                |periph_control[TIMER_SELECT_LSB+2*i +: 2];
        end
    end

    // pin drive, pullups and peripheral overrides
    always_comb begin
        // analog pins: no pullup, float unless output
        next_analog_pin_out = analog_port_data;
        next_analog_pin_oe = analog_port_direction;

        next_bidir_pin_out = bidir_port_data;
        next_bidir_pin_oe = bidir_port_direction;
        // output direction disables pullup automatically
        next_bidir_pullup_on = bidir_port_pullup_enable & ~bidir_port_direction;
        // can controller takes transmit out and receive in
        if (periph_control[CAN_PIN_ENABLE_BIT]) begin
            next_bidir_pin_out[CAN_TRANSMIT_PIN] = can_transmit;
            next_bidir_pin_oe[CAN_TRANSMIT_PIN] = 1'b1;
            next_bidir_pin_oe[CAN_RECEIVE_PIN] = 1'b0;
            next_bidir_pullup_on[CAN_TRANSMIT_PIN] = 1'b0;
            next_bidir_pullup_on[CAN_RECEIVE_PIN] = 1'b0;
        end

        next_shared_pin_out = shared_port_data;
        next_shared_pin_oe = shared_port_direction;
        // claimed pins ignore direction, pullups only on port inputs
        next_shared_pullup_on = shared_port_pullup_enable & ~shared_port_direction
            & ~shared_claimed;
        if (shared_claimed[SLAVE_SELECT_PIN]) begin
            next_shared_pin_oe[SLAVE_SELECT_PIN] = 1'b0;
        end
        if (shared_claimed[MASTER_IN_PIN]) begin
            // a slave drives master-in, a master listens on it
            next_shared_pin_out[MASTER_IN_PIN] = serial_periph_master_in_out;
            next_shared_pin_oe[MASTER_IN_PIN] = !periph_control[SERIAL_PERIPH_MASTER_SELECT_BIT];
        end
        if (shared_claimed[MASTER_OUT_PIN]) begin
            next_shared_pin_out[MASTER_OUT_PIN] = serial_periph_master_out;
            next_shared_pin_oe[MASTER_OUT_PIN] = periph_control[SERIAL_PERIPH_MASTER_SELECT_BIT];
        end
        if (shared_claimed[SERIAL_PERIPH_CLOCK_PIN]) begin
            next_shared_pin_out[SERIAL_PERIPH_CLOCK_PIN] = serial_periph_clock_out;
            next_shared_pin_oe[SERIAL_PERIPH_CLOCK_PIN] =
                periph_control[SERIAL_PERIPH_MASTER_SELECT_BIT];
        end
        // the timer decides drive itself, a capture channel leaves the pin undriven
        for (int i = 0; i < 4; i++) begin
            if (shared_claimed[TIMER_PIN_LSB+i]) begin
                next_shared_pin_out[TIMER_PIN_LSB+i] = timer_channel_out[i];
                next_shared_pin_oe[TIMER_PIN_LSB+i] = timer_channel_oe[i];
            end
        end
    end

    // outputs registered; the latch may be loaded before enabling
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_READ;
            analog_pin_out <= '0;
            analog_pin_oe <= '0;
            bidir_pin_out <= '0;
            bidir_pin_oe <= '0;
            bidir_pullup_on <= '0;
            shared_pin_out <= '0;
            shared_pin_oe <= '0;
            shared_pullup_on <= '0;
            can_pin_enable <= 1'b0;
            serial_periph_enable <= 1'b0;
            serial_periph_master_select <= 1'b0;
            timer_edge_level_select <= '0;
        end else begin
            wb_ack_o <= next_wb_ack_o;
            wb_dat_o <= next_wb_dat_o;
            analog_pin_out <= next_analog_pin_out;
            analog_pin_oe <= next_analog_pin_oe;
            bidir_pin_out <= next_bidir_pin_out;
            bidir_pin_oe <= next_bidir_pin_oe;
            bidir_pullup_on <= next_bidir_pullup_on;
            shared_pin_out <= next_shared_pin_out;
            shared_pin_oe <= next_shared_pin_oe;
            shared_pullup_on <= next_shared_pullup_on;
            can_pin_enable <= next_periph_control[CAN_PIN_ENABLE_BIT];
            serial_periph_enable <= next_periph_control[SERIAL_PERIPH_ENABLE_BIT];
            serial_periph_master_select <= next_periph_control[SERIAL_PERIPH_MASTER_SELECT_BIT];
            timer_edge_level_select <= next_periph_control[TIMER_SELECT_LSB +: 8];
        end
    end

endmodule : gpio_ports_b_c_d
`default_nettype wire

// >>> hdl/gpio_ports_pkg.sv
// constants for the analog, bidirectional and shared general-purpose ports
package gpio_ports_pkg;
    // register byte addresses (bus word aligned)
    localparam logic [7:0] ANALOG_PORT_DATA_ADDR = 8'h04;
    localparam logic [7:0] BIDIR_PORT_DATA_ADDR = 8'h08;
    localparam logic [7:0] SHARED_PORT_DATA_ADDR = 8'h0c;
    localparam logic [7:0] ANALOG_PORT_DIRECTION_ADDR = 8'h10;
    localparam logic [7:0] BIDIR_PORT_DIRECTION_ADDR = 8'h14;
    localparam logic [7:0] SHARED_PORT_DIRECTION_ADDR = 8'h18;
    localparam logic [7:0] BIDIR_PORT_PULLUP_ENABLE_ADDR = 8'h1c;
    localparam logic [7:0] SHARED_PORT_PULLUP_ENABLE_ADDR = 8'h20;
    localparam logic [7:0] PERIPH_CONTROL_ADDR = 8'h24;
    // periph control fields
    localparam int CAN_PIN_ENABLE_BIT = 0;
    localparam int SERIAL_PERIPH_ENABLE_BIT = 1;
    localparam int SERIAL_PERIPH_MASTER_SELECT_BIT = 2;
    localparam int TIMER_SELECT_LSB = 8; // four 2-bit fields, timer_one_channel_zero_pin,timer_one_channel_one_pin,timer_two_channel_zero_pin,timer_two_channel_one_pin
    // widths and reset values
    localparam int ANALOG_WIDTH = 8;
    localparam int BIDIR_WIDTH = 7;
    localparam int SHARED_WIDTH = 8;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [15:0] PERIPH_CONTROL_RESET = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    // shared port pin positions
    localparam int SLAVE_SELECT_PIN = 0;
    localparam int MASTER_IN_PIN = 1;
    localparam int MASTER_OUT_PIN = 2;
    localparam int SERIAL_PERIPH_CLOCK_PIN = 3;
    localparam int TIMER_PIN_LSB = 4;
    // bidirectional port can pins
    localparam int CAN_TRANSMIT_PIN = 0;
    localparam int CAN_RECEIVE_PIN = 1;
endpackage : gpio_ports_pkg
